/* verilog/ovfc_ctrl.sv */
// Output overvoltage fault controller with a Wishbone register slave.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RULE1] Trip after sense stays high for delay.
// [RULE2] Default trip latches high side off, power good low.
// [RULE3] Low side on while sense stays high.
// [RULE4] Latch clears on bias, enable or operation cycle.
// [RULE5] Ignore mode keeps both drives under normal control.
// [RULE6] Every trip sets fault flag and alert.
// [RULE7] Threshold clamps to setting plus 655 mV.
// [RULE8] Same threshold and response in both modes.
// [RULE9] Fault flag sticky until clear or reset.
// [RULE10] Delay counted in clock cycles, parameterised.
module ovfc_ctrl
  import ovfc_pkg::*;
#(
  parameter int unsigned QUAL_CYC = OVFC_QUAL_CYC
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog side and system levels.
  input wire logic ov_cmp_i,
  input wire logic pg_window_i,
  input wire logic bias_ok_i,
  input wire logic enable_i,
  input wire logic svid_mode_i,
  input wire logic [15:0] svid_vout_mv_i,
  output logic [15:0] eff_ov_thresh_o,
  // Modulator requests and gate drives.
  input wire logic pwm_hs_i,
  input wire logic pwm_ls_i,
  output logic high_side_gate_drive_o,
  output logic low_side_gate_drive_o,
  // Open-drain status pins.
  output logic power_good_out_o,
  output logic power_good_out_oe_o,
  output logic fault_alert_out_o,
  output logic fault_alert_out_oe_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  ovfc_trip_if trip_if ();

  // Qualifier that turns the raw comparator into a trip.
  ovfc_qual #(
    .QUAL_CYC(QUAL_CYC)
  ) u_qual (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .trip_if(trip_if)
  );

  assign trip_if.cmp = ov_cmp_i;

  // Byte-lane merge for the low sixteen bits of a register.
  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] dat,
                                       input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = dat[15:8];
    end
    return res;
  endfunction

  // Software state.
  logic opon_q, opon_d;          // Operation on; writing zero is the off command.
  logic ign_q, ign_d;            // Response select: one ignores trips.
  logic [15:0] limit_q, limit_d; // Programmed overvoltage threshold.
  logic [15:0] vset_q, vset_d;   // Output setting used in host mode.
  // Fault state.
  logic flag_q, flag_d;          // Sticky overvoltage fault flag.
  logic latch_q, latch_d;        // High-side off latch.
  logic trip_prev_q, trip_prev_d; // Trip of the previous cycle, for edge detect.
  // Bus answer.
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  // Outputs.
  logic [15:0] eff_q, eff_d;
  logic hs_q, hs_d;
  logic ls_q, ls_d;
  logic pg_q, pg_d;
  // Combinational helpers.
  logic bus_acc;                 // A new bus request this cycle.
  logic wr_acc;                  // A new write request this cycle.
  logic clr_wr;                  // Write of the clear-faults command.
  logic run;                     // Conversion allowed by bias, enable and operation.
  logic [15:0] vout_mv;          // Output setting of whichever interface rules.
  logic [16:0] cap_mv;           // Setting plus tracking offset.
  logic trip_rise;

  // Bus decode and fault flag logic share one next-state process.
  always_comb begin
    bus_acc = wb_cyc_i && wb_stb_i && !ack_q;
    wr_acc = bus_acc && wb_we_i;
    clr_wr = wr_acc && (wb_adr_i == OVFC_CMD_OFS) && wb_sel_i[0] &&
             wb_dat_i[OVFC_CMD_CLR_BIT];
    // Rising edge of the qualified trip.
    trip_rise = trip_if.trip && !trip_prev_q;
    // One threshold path serves both control interfaces.
    vout_mv = svid_mode_i ? svid_vout_mv_i : vset_q; // see [RULE8]
    cap_mv = {1'b0, vout_mv} + {1'b0, OVFC_TRACK_OFS_MV};
    // A limit above the cap is replaced by the tracking value.
    eff_d = ({1'b0, limit_q} > cap_mv) ? cap_mv[15:0] : limit_q; // see [RULE7]
    // Switching is allowed only with bias, enable and operation all on.
    run = bias_ok_i && enable_i && opon_q;

    // Every request is answered exactly one cycle after it is taken.
    ack_d = bus_acc;
    rdat_d = rdat_q;
    opon_d = opon_q;
    ign_d = ign_q;
    limit_d = limit_q;
    vset_d = vset_q;
    // Writes take effect on the edge that raises the acknowledge.
    if (wr_acc) begin
      if (wb_adr_i == OVFC_CTRL_OFS) begin
        if (wb_sel_i[0]) begin
          opon_d = wb_dat_i[OVFC_CTRL_OPON_BIT];
          ign_d = wb_dat_i[OVFC_CTRL_IGN_BIT];
        end
      end else if (wb_adr_i == OVFC_LIMIT_OFS) begin
        limit_d = wr16(limit_q, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == OVFC_VSET_OFS) begin
        vset_d = wr16(vset_q, wb_dat_i, wb_sel_i);
      end
    end
    // Reads return zero for unmapped and write-only addresses.
    if (bus_acc && !wb_we_i) begin
      rdat_d = 32'h0000_0000;
      if (wb_adr_i == OVFC_CTRL_OFS) begin
        rdat_d[OVFC_CTRL_OPON_BIT] = opon_q;
        rdat_d[OVFC_CTRL_IGN_BIT] = ign_q;
      end else if (wb_adr_i == OVFC_LIMIT_OFS) begin
        rdat_d[15:0] = limit_q;
      end else if (wb_adr_i == OVFC_VSET_OFS) begin
        rdat_d[15:0] = vset_q;
      end else if (wb_adr_i == OVFC_STAT_OFS) begin
        rdat_d[OVFC_STAT_FLAG_BIT] = flag_q;
        rdat_d[OVFC_STAT_TRIP_BIT] = trip_if.trip;
        rdat_d[OVFC_STAT_LATCH_BIT] = latch_q;
        rdat_d[OVFC_STAT_SVID_BIT] = svid_mode_i;
        rdat_d[OVFC_STAT_EFF_LSB +: 16] = eff_q;
      end
    end

    // The flag is set by any trip in any mode; a clear in the same cycle loses.
    flag_d = flag_q;
    if (clr_wr) begin
      flag_d = 1'b0; // see [RULE9]
    end
    if (trip_rise || trip_if.trip) begin
      flag_d = 1'b1; // see [RULE6]
    end

    // The latch is cleared while bias, enable or operation is off; a trip under the default response still sets it.
    latch_d = latch_q;
    if (!run) begin
      latch_d = 1'b0; // see [RULE4]
    end
    if (trip_if.trip && !ign_q) begin
      latch_d = 1'b1; // see [RULE2]
    end
    // Remember the trip for the next cycle's edge detect.
    trip_prev_d = trip_if.trip;
  end

  // Gate drive and power good next values.
  always_comb begin
    // Using the latch's next value turns the high side off on the same edge that sets the latch.
    hs_d = pwm_hs_i && run && (ign_q || !latch_d); // see [RULE2] see [RULE5]
    if (!ign_q && latch_d) begin
      // While latched the low side follows the comparator, not the modulator.
      ls_d = ov_cmp_i; // see [RULE3]
    end else begin
      // Otherwise the modulator drives the low side while running.
      ls_d = pwm_ls_i && run; // see [RULE5]
    end
    // Power good is forced low while the default response holds the latch.
    pg_d = pg_window_i && run && (ign_q || !latch_d); // see [RULE2]
  end

  // Register every group of state.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      opon_q <= OVFC_OPON_RST;
      ign_q <= OVFC_IGN_RST;
      limit_q <= OVFC_LIMIT_RST;
      vset_q <= OVFC_VSET_RST;
      flag_q <= 1'b0;
      latch_q <= 1'b0;
      trip_prev_q <= 1'b0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      eff_q <= OVFC_LIMIT_RST;
      hs_q <= 1'b0;
      ls_q <= 1'b0;
      pg_q <= 1'b0;
    end else begin
      opon_q <= opon_d;
      ign_q <= ign_d;
      limit_q <= limit_d;
      vset_q <= vset_d;
      flag_q <= flag_d;
      latch_q <= latch_d;
      trip_prev_q <= trip_prev_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      eff_q <= eff_d;
      hs_q <= hs_d;
      ls_q <= ls_d;
      pg_q <= pg_d;
    end
  end

  // Open-drain pins pull low when enabled and float high otherwise.
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign eff_ov_thresh_o = eff_q;
  assign high_side_gate_drive_o = hs_q;
  assign low_side_gate_drive_o = ls_q;
  // The data side of both open-drain pins is always low; only the enables move.
  assign power_good_out_o = 1'b0;
  assign power_good_out_oe_o = !pg_q;
  assign fault_alert_out_o = 1'b0;
  assign fault_alert_out_oe_o = flag_q; // see [RULE6]

  // A trip under the default response kills the high side on the next edge.
  AST_HS_OFF_ON_TRIP: assert property ( // see [RULE2]
    trip_if.trip && !ign_q |=> !high_side_gate_drive_o)
    else $error("High side still on after a trip.");
  // Power good is pulled low at the same time.
  AST_PG_LOW_ON_TRIP: assert property ( // see [RULE2]
    trip_if.trip && !ign_q |=> power_good_out_oe_o)
    else $error("Power good not pulled low after a trip.");
  // While latched the low side mirrors the comparator one cycle later.
  AST_LS_FOLLOWS_CMP: assert property ( // see [RULE3]
    latch_d && !ign_q |=> low_side_gate_drive_o == $past(ov_cmp_i))
    else $error("Low side does not follow the comparator while latched.");
  // Latch stays set while the system keeps running.
  AST_LATCH_HOLDS: assert property (latch_q && run |=> latch_q) // see [RULE4]
    else $error("High-side latch released without a power cycle.");
  // Dropping enable with no trip clears the latch.
  AST_LATCH_CLEARS: assert property ( // see [RULE4]
    latch_q && !enable_i && !trip_if.trip |=> !latch_q)
    else $error("High-side latch not cleared by an enable cycle.");
  // After two cycles of ignore mode while running, the modulator passes straight through.
  AST_IGNORE_PASSES: assert property (ign_q && run ##1 ign_q && run |=> // see [RULE5]
    high_side_gate_drive_o == $past(pwm_hs_i) && low_side_gate_drive_o == $past(pwm_ls_i))
    else $error("Ignore mode altered the gate drives.");
  // Each trip shows in the flag and the alert pin on the next edge.
  AST_FLAG_ON_TRIP: assert property ( // see [RULE6]
    $rose(trip_if.trip) |=> flag_q && fault_alert_out_oe_o)
    else $error("Trip not flagged or alert not raised.");
  // Without a clear command the flag never falls.
  AST_FLAG_STICKY: assert property (flag_q && !clr_wr |=> flag_q) // see [RULE9]
    else $error("Fault flag dropped without a clear.");
  // The effective threshold never exceeds the setting plus the offset.
  AST_EFF_CLAMP: assert property (##1 ({1'b0, eff_ov_thresh_o} <= $past(cap_mv)) && // see [RULE7]
    (eff_ov_thresh_o <= $past(limit_q)))
    else $error("Effective threshold exceeds its clamp or the limit.");
  // In serial VID mode the clamp tracks the serial setting.
  AST_SVID_TRACK: assert property (svid_mode_i |=> // see [RULE8]
    {1'b0, eff_ov_thresh_o} <= {1'b0, $past(svid_vout_mv_i)} + {1'b0, OVFC_TRACK_OFS_MV})
    else $error("Serial VID threshold not clamped to its setting.");
  // The bus answers one cycle after a request and drops the next cycle.
  AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Wishbone acknowledge timing broken.");
  // A held latch keeps the high side off while the system keeps running.
  AST_HS_STAYS_OFF: assert property ( // see [RULE4]
    latch_q && !ign_q && run |=> !high_side_gate_drive_o)
    else $error("High side came back while the latch was held.");
  // Once the sense voltage is back below the threshold the low side lets go.
  AST_LS_RELEASES: assert property ( // see [RULE3]
    latch_q && !ign_q && !ov_cmp_i |=> !low_side_gate_drive_o)
    else $error("Low side still on after the overvoltage ended.");
  // A clear with no trip pending drops the flag and the alert.
  AST_FLAG_CLEARS: assert property ( // see [RULE9]
    clr_wr && !trip_if.trip |=> !flag_q && !fault_alert_out_oe_o)
    else $error("Fault flag survived a clear with no trip.");
  // Ignore mode never sets the high-side latch.
  AST_IGN_NO_LATCH: assert property ( // see [RULE5]
    ign_q && !latch_q |=> !latch_q)
    else $error("Latch set although trips are ignored.");
  // A trip in any mode raises the alert on the next edge.
  AST_ALERT_ANY_MODE: assert property ( // see [RULE6]
    trip_if.trip |=> fault_alert_out_oe_o)
    else $error("Alert not raised during a trip.");
endmodule // ovfc_ctrl
`default_nettype wire

/* verilog/ovfc_pkg.sv */
// Shared constants for the output overvoltage fault control block.
`default_nettype none
package ovfc_pkg;
  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] OVFC_CTRL_OFS = 8'h00;
  localparam logic [7:0] OVFC_LIMIT_OFS = 8'h04;
  localparam logic [7:0] OVFC_VSET_OFS = 8'h08;
  localparam logic [7:0] OVFC_STAT_OFS = 8'h0C;
  localparam logic [7:0] OVFC_CMD_OFS = 8'h10;
  // Control register fields.
  localparam int OVFC_CTRL_OPON_BIT = 0;
  localparam int OVFC_CTRL_IGN_BIT = 1;
  // Status register fields.
  localparam int OVFC_STAT_FLAG_BIT = 0;
  localparam int OVFC_STAT_TRIP_BIT = 1;
  localparam int OVFC_STAT_LATCH_BIT = 2;
  localparam int OVFC_STAT_SVID_BIT = 3;
  localparam int OVFC_STAT_EFF_LSB = 16;
  // Command register fields.
  localparam int OVFC_CMD_CLR_BIT = 0;
  // Reset values, all thresholds and settings in millivolts.
  localparam logic OVFC_OPON_RST = 1'b1;
  localparam logic OVFC_IGN_RST = 1'b0;
  localparam logic [15:0] OVFC_LIMIT_RST = 16'h0546;
  localparam logic [15:0] OVFC_VSET_RST = 16'h03E8;
  // Tracking offset added to the output setting to cap the programmed threshold.
  localparam logic [15:0] OVFC_TRACK_OFS_MV = 16'h028F;
  // Trip qualification time and the clock period it is counted in.
  localparam int OVFC_QUAL_NS = 200;
  localparam int OVFC_CLK_NS = 100;
  localparam int OVFC_QUAL_CYC = (OVFC_QUAL_NS + OVFC_CLK_NS - 1) / OVFC_CLK_NS;
endpackage
`default_nettype wire

/* verilog/ovfc_trip_if.sv */
// Carrier between the controller and its trip qualifier.
`timescale 1ns/1ps
`default_nettype none
interface ovfc_trip_if;
  logic cmp;  // Raw comparator: sense voltage above active threshold.
  logic trip; // Qualified overvoltage trip.
  // The qualifier filters the comparator into a trip.
  modport qual (input cmp, output trip);
  // The controller feeds the comparator and consumes the trip.
  modport ctrl (output cmp, input trip);
endinterface
`default_nettype wire

/* verilog/ovfc_qual.sv */
// Trip qualifier that delays the overvoltage comparator by a cycle count.
`timescale 1ns/1ps
`default_nettype none
module ovfc_qual
  import ovfc_pkg::*;
#(
  parameter int unsigned QUAL_CYC = OVFC_QUAL_CYC
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Comparator in, trip out.
  ovfc_trip_if.qual trip_if
);
  // A counter of eight bits bounds the delay; refuse what it cannot hold.
  if (QUAL_CYC < 1 || QUAL_CYC > 255) begin : g_bad_cyc
    $error("QUAL_CYC must lie between 1 and 255.");
  end

  localparam logic [7:0] QualLim = QUAL_CYC[7:0];

  logic [7:0] cnt_q, cnt_d; // Consecutive cycles with the comparator high.
  logic trip_q, trip_d;     // Registered trip, glitch free for the controller.

  // Count while the comparator stays high; any low sample restarts the count.
  always_comb begin
    cnt_d = 8'h00;
    trip_d = 1'b0;
    if (trip_if.cmp) begin
      cnt_d = (cnt_q == QualLim) ? cnt_q : cnt_q + 8'h01; // see [RULE10]
      // Comparing against the limit minus one lets the registered trip rise on the edge the count reaches the limit.
      trip_d = (cnt_q >= (QualLim - 8'h01));              // see [RULE1]
    end
  end

  // Register the count and the trip.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      cnt_q <= 8'h00;
      trip_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      trip_q <= trip_d;
    end
  end

  assign trip_if.trip = trip_q;

  // The trip appears only after the comparator has been high for the full delay.
  AST_TRIP_QUALIFIED: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [RULE1]
    $rose(trip_q) |-> (cnt_q >= QualLim - 8'h01) && $past(trip_if.cmp))
    else $error("Trip rose before the qualification delay.");
  // A low comparator sample drops the trip on the next edge.
  AST_TRIP_DROPS: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see [RULE10]
    !trip_if.cmp |=> !trip_q && (cnt_q == 8'h00))
    else $error("Trip or count survived a low comparator sample.");
endmodule // ovfc_qual
`default_nettype wire

/* tb/ovfc_sense_model.sv */
// Analog side model: overvoltage and power good comparators on the sense voltage.
`timescale 1ns/1ps
`default_nettype none
module ovfc_sense_model #(
  parameter logic [15:0] PG_LO_MV = 16'h0384,
  parameter logic [15:0] PG_HI_MV = 16'h044C
) (
  // Sense voltage and the threshold from the block.
  input wire logic [15:0] sense_mv_i,
  input wire logic [15:0] eff_thr_i,
  // Comparator levels.
  output logic ov_cmp_o,
  output logic pg_window_o
);
  // Strictly above trips; at the threshold does not, like a real comparator.
  assign ov_cmp_o = sense_mv_i > eff_thr_i;
  // Window comparator for power good.
  assign pg_window_o = (sense_mv_i >= PG_LO_MV) && (sense_mv_i <= PG_HI_MV);
endmodule // ovfc_sense_model
`default_nettype wire

/* tb/ovfc_ctrl_tb.sv */
// Self-checking bench for the overvoltage fault controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin err_total++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module ovfc_ctrl_tb;
  import ovfc_pkg::*;
  // Clock, reset and bus.
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, q;
  // Analog and system levels.
  logic [15:0] sense = 16'h03E8, svid_mv = 16'h03E8, eff;
  logic cmp, pgw, bias = 1'b1, en = 1'b1, svid = 1'b0, phs = 1'b1, pls = 1'b0;
  logic hs, ls, pg, pg_oe, al, al_oe;
  int err_total = 0;
  int total_checks = 0;
  // Clock at 10 MHz.
  always #50 sys_clk_i = ~sys_clk_i;
  ovfc_sense_model model (.sense_mv_i(sense), .eff_thr_i(eff), .ov_cmp_o(cmp),
    .pg_window_o(pgw));
  ovfc_ctrl #(.QUAL_CYC(2)) dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .ov_cmp_i(cmp), .pg_window_i(pgw), .bias_ok_i(bias),
    .enable_i(en), .svid_mode_i(svid), .svid_vout_mv_i(svid_mv), .eff_ov_thresh_o(eff),
    .pwm_hs_i(phs), .pwm_ls_i(pls), .high_side_gate_drive_o(hs),
    .low_side_gate_drive_o(ls), .power_good_out_o(pg), .power_good_out_oe_o(pg_oe),
    .fault_alert_out_o(al), .fault_alert_out_oe_o(al_oe));
  // Waits whole cycles; values read right after an edge are the settled ones.
  task automatic clk(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // One classic Wishbone cycle, held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  // Reset values, unclamped effective threshold at reset and an unmapped read.
  task automatic t_reset;
    wb(1'b0, OVFC_CTRL_OFS, 32'h0);
    `CHK("ctrl", 32'h1, q)
    `CHK("pg data", 1'b0, pg)
    `CHK("alert data", 1'b0, al)
    wb(1'b0, OVFC_STAT_OFS, 32'h0);
    `CHK("eff", 16'h0546, q[31:16])
    wb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, q)
    $display("test reset done");
  endtask
  // A one-cycle spike must not trip; a held one must.
  task automatic t_trip;
    sense <= 16'h0600;
    clk(1);
    sense <= 16'h03E8;
    clk(5);
    `CHK("hs glitch", 1'b1, hs)
    `CHK("alert glitch", 1'b0, al_oe)
    sense <= 16'h0600;
    clk(5);
    `CHK("hs off", 1'b0, hs)
    `CHK("pg low", 1'b1, pg_oe)
    `CHK("ls on", 1'b1, ls)
    `CHK("alert", 1'b1, al_oe)
    sense <= 16'h03E8;
    clk(4);
    `CHK("ls off", 1'b0, ls)
    `CHK("hs latched", 1'b0, hs)
    `CHK("pg latched", 1'b1, pg_oe)
    wb(1'b0, OVFC_STAT_OFS, 32'h0);
    `CHK("status", 3'b101, q[2:0])
  endtask
  // Each of the three clear methods releases the latch; the flag stays.
  task automatic t_clear(input int m);
    t_trip();
    if (m == 0) begin
      en <= 1'b0; clk(2); en <= 1'b1;
    end else if (m == 1) begin
      bias <= 1'b0; clk(2); bias <= 1'b1;
    end else begin
      wb(1'b1, OVFC_CTRL_OFS, 32'h0);
      wb(1'b1, OVFC_CTRL_OFS, 32'h1);
    end
    clk(4);
    `CHK("hs back", 1'b1, hs)
    `CHK("pg good", 1'b0, pg_oe)
    `CHK("flag held", 1'b1, al_oe)
    wb(1'b1, OVFC_CMD_OFS, 32'h1);
    clk(2);
    `CHK("flag clr", 1'b0, al_oe)
    $display("test clear %0d done", m);
  endtask
  // Ignore mode keeps both drives with the modulator but still flags.
  task automatic t_ignore;
    wb(1'b1, OVFC_CTRL_OFS, 32'h3);
    sense <= 16'h0600;
    clk(5);
    `CHK("ign hs", 1'b1, hs)
    `CHK("ign flag", 1'b1, al_oe)
    phs <= 1'b0; pls <= 1'b1;
    clk(3);
    `CHK("ign ls", 1'b1, ls)
    `CHK("ign hs2", 1'b0, hs)
    // A clear while the trip still stands must lose to the trip.
    wb(1'b1, OVFC_CMD_OFS, 32'h1);
    `CHK("flag over clr", 1'b1, al_oe)
    sense <= 16'h03E8; phs <= 1'b1; pls <= 1'b0;
    wb(1'b1, OVFC_CTRL_OFS, 32'h1);
    en <= 1'b0; clk(2); en <= 1'b1;
    wb(1'b1, OVFC_CMD_OFS, 32'h1);
    clk(2);
    `CHK("ign clr", 1'b0, al_oe)
    $display("test ignore done");
  endtask
  // Tracking clamp in host mode and in serial mode, with a trip in serial mode.
  task automatic t_clamp;
    wb(1'b1, OVFC_LIMIT_OFS, 32'h0FFF);
    clk(2);
    `CHK("clamp", 16'h0677, eff)
    svid <= 1'b1; svid_mv <= 16'h0320;
    clk(3);
    `CHK("svid clamp", 16'h05AF, eff)
    sense <= 16'h05B0;
    clk(5);
    `CHK("svid trip", 1'b0, hs)
    sense <= 16'h03E8; svid <= 1'b0;
    en <= 1'b0; clk(2); en <= 1'b1;
    clk(3);
    $display("test clamp done");
  endtask
  // Verdict and the single end of the run.
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog: the tests need well under 2000 cycles.
  initial begin
    clk(2000);
    err_total++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    clk(8);
    rstn_i <= 1'b1;
    clk(1);
    t_reset();
    for (int m = 0; m < 3; m++) t_clear(m);
    t_ignore();
    t_clamp();
    end_of_test();
  end
endmodule // ovfc_ctrl_tb
`default_nettype wire
